// *** ufir_evt_model.sv ***
// Purpose: far-side event source for the interrupt request registers
// Assumes: each event is a one-clock pulse launched just after a rising edge
// Notes: every event line idles low between pulses
`timescale 1ns/1ps
`default_nettype none
module ufir_evt_model (
   input wire logic clk,
   output logic [6:0] bus_ev,
   output logic [7:0] ep_ev,
   output logic [5:0] pnak_ev,
   output logic [5:0] ibn_ev,
   output logic [3:0] pid_ev,
   output logic [3:0] drop_ev,
   output logic [1:0] wave_ev
);
   initial begin
      {bus_ev, ep_ev, pnak_ev, ibn_ev, pid_ev, drop_ev, wave_ev} = '0;
   end
   // Requests other than the FIFO flag ones come only from here, so a write can never look like an event
   task automatic pulse(input logic [6:0] b, input logic [7:0] e, input logic [5:0] p,
      input logic [5:0] i, input logic [3:0] pe, input logic [3:0] d, input logic [1:0] w);
      begin
         @(posedge clk);
         {bus_ev, ep_ev, pnak_ev, ibn_ev, pid_ev, drop_ev, wave_ev} <= {b, e, p, i, pe, d, w};
         @(posedge clk);
         {bus_ev, ep_ev, pnak_ev, ibn_ev, pid_ev, drop_ev, wave_ev} <= '0;
      end
   endtask
endmodule
`default_nettype wire

// *** ufir_pkg.sv ***
// Purpose: constants for the USB FIFO interrupt request register group
// Assumes: 8-bit registers, each on one aligned 32-bit AHB word
// Notes: byte address is four times the register index
package ufir_pkg;
   localparam int unsigned UFIR_NREG = 21;
   localparam logic [15:0] UFIR_IDX_BASE = 16'hE653;
   localparam logic [15:0] UFIR_IDX_EP4_REQ = 16'hE653;
   localparam logic [15:0] UFIR_IDX_EP6_EN = 16'hE654;
   localparam logic [15:0] UFIR_IDX_EP6_REQ = 16'hE655;
   localparam logic [15:0] UFIR_IDX_EP8_EN = 16'hE656;
   localparam logic [15:0] UFIR_IDX_EP8_REQ = 16'hE657;
   localparam logic [15:0] UFIR_IDX_BNAK_EN = 16'hE658;
   localparam logic [15:0] UFIR_IDX_BNAK_REQ = 16'hE659;
   localparam logic [15:0] UFIR_IDX_PNAK_EN = 16'hE65A;
   localparam logic [15:0] UFIR_IDX_PNAK_REQ = 16'hE65B;
   localparam logic [15:0] UFIR_IDX_BUS_EN = 16'hE65C;
   localparam logic [15:0] UFIR_IDX_BUS_REQ = 16'hE65D;
   localparam logic [15:0] UFIR_IDX_EP_EN = 16'hE65E;
   localparam logic [15:0] UFIR_IDX_EP_REQ = 16'hE65F;
   localparam logic [15:0] UFIR_IDX_WAVE_EN = 16'hE660;
   localparam logic [15:0] UFIR_IDX_WAVE_REQ = 16'hE661;
   localparam logic [15:0] UFIR_IDX_ERR_EN = 16'hE662;
   localparam logic [15:0] UFIR_IDX_ERR_REQ = 16'hE663;
   localparam logic [15:0] UFIR_IDX_ERRCNT = 16'hE664;
   localparam logic [15:0] UFIR_IDX_ERRCLR = 16'hE665;
   localparam logic [15:0] UFIR_IDX_BUSVEC = 16'hE666;
   localparam logic [15:0] UFIR_IDX_FIFOVEC = 16'hE667;
   // Writable masks per register kind
   localparam logic [7:0] UFIR_FIFO_REQ_MASK = 8'h07;
   localparam logic [7:0] UFIR_FIFO_EN_MASK = 8'h0F;
   localparam logic [7:0] UFIR_BNAK_MASK = 8'h3F;
   localparam logic [7:0] UFIR_PNAK_MASK = 8'hFD;
   localparam logic [7:0] UFIR_BUS_MASK = 8'h7F;
   localparam logic [7:0] UFIR_EP_MASK = 8'hFF;
   localparam logic [7:0] UFIR_WAVE_MASK = 8'h03;
   localparam logic [7:0] UFIR_ERR_MASK = 8'hF1;
   localparam logic [7:0] UFIR_REG_RESET = 8'h00;
   localparam logic [3:0] UFIR_LIMIT_RESET = 4'h4;
   localparam logic [7:0] UFIR_FIFOVEC_BASE = 8'h80;
   localparam int unsigned UFIR_BNAK_BIT = 0;
   localparam int unsigned UFIR_ERRLIM_BIT = 0;
   typedef enum logic [1:0] {UFIR_IDLE = 2'b00, UFIR_WDATA = 2'b01} ufir_state_t;
endpackage

// *** ufir_top.sv ***
// Purpose: interrupt enable and request registers of a USB peripheral
// Assumes: one 200 MHz clock; event inputs are one-cycle pulses from same-clock logic
// Notes: AHB-Lite slave, zero wait states, always OKAY
// What this block does
// - Request bits are set only by their hardware events, never by writes.
// - Writing one clears a request bit; writing zero leaves it.
// - Waveform request holds hook at bit 1 and done at bit 0.
// - Iso endpoints 2,4,6,8 raise error on PID error or drop.
// - Error register: read-only count in 7:4, writable limit 3:0 resetting to four.
// - Any write to the clear register zeroes the error count.
// - Bus vector register is read-only, vector in bits 6:2, resets zero.
// - FIFO vector reads bit 7 one, bit 6 zero, vector 5:2.
// - Ping-NAK request set for OUT endpoints 0,1,2,4,6,8 pinged and NAKed.
// - Ping-NAK bit 0 summarises in-bulk-NAK; bit 1 reads zero.
// - FIFO enables hold programmable, empty, full plus edge select bit 3.
// - Error enable has iso endpoints 8,6,4,2 in 7:4, limit in 0.
`timescale 1ns/1ps
`default_nettype none
module ufir_top
   import ufir_pkg::*;
(
   input wire logic CLK,
   input wire logic NRST,
   input wire logic HSEL,
   input wire logic [17:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [2:0] HSIZE,
   input wire logic HREADY,
   input wire logic [31:0] HWDATA,
   output logic [31:0] HRDATA,
   output logic HREADYOUT,
   output logic HRESP,
   input wire logic [2:0] EP4_FLAG_IN,
   input wire logic [2:0] EP6_FLAG_IN,
   input wire logic [2:0] EP8_FLAG_IN,
   input wire logic [5:0] IN_BULK_NAK_EV,
   input wire logic [5:0] PING_NAK_EV,
   input wire logic [6:0] BUS_EVENT_EV,
   input wire logic [7:0] ENDPOINT_EV,
   input wire logic WAVEFORM_HOOK_EV,
   input wire logic WAVEFORM_DONE_EV,
   input wire logic [3:0] ISO_PID_ERR_EV,
   input wire logic [3:0] ISO_DROP_EV,
   input wire logic [4:0] BUS_VECTOR_IN,
   input wire logic [3:0] FIFO_VECTOR_IN,
   output logic BUS_IRQ,
   output logic FIFO_IRQ
);
   import ufir_pkg::*;

   logic rst_meta_reg, rst_sync_reg;
   logic [7:0] regs_reg [UFIR_NREG];
   logic [3:0] err_count_reg;
   logic [8:0] flag_meta_reg, flag_sync_reg, flag_prev_reg;
   logic [4:0] bus_vec_reg;
   logic [3:0] fifo_vec_reg;
   ufir_state_t state_reg;
   logic [4:0] widx_reg;
   logic wsel_reg;
   logic [7:0] wdata;
   logic [4:0] aidx;
   logic aok;
   logic [7:0] set_vec [UFIR_NREG];
   logic [7:0] wmask [UFIR_NREG];
   logic [8:0] flag_ev;
   logic lim_hit;

   // Reset released through two flops
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         rst_meta_reg <= 1'b0;
         rst_sync_reg <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_sync_reg <= rst_meta_reg;
      end
   end

   // FIFO flags are pin levels: synchronise before edge detect
   always_ff @(posedge CLK or negedge rst_sync_reg) begin
      if (!rst_sync_reg) begin
         flag_meta_reg <= 9'h000;
         flag_sync_reg <= 9'h000;
         flag_prev_reg <= 9'h000;
      end else begin
         flag_meta_reg <= {EP8_FLAG_IN, EP6_FLAG_IN, EP4_FLAG_IN};
         flag_sync_reg <= flag_meta_reg;
         flag_prev_reg <= flag_sync_reg;
      end
   end

   // Programmable flag edge chosen per endpoint for ep6 and ep8, ep4 rising; empty/full on rising edge
   always_comb begin
      for (int e = 0; e < 3; e++) begin
         for (int b = 0; b < 3; b++) begin
            flag_ev[e*3+b] = flag_sync_reg[e*3+b] & ~flag_prev_reg[e*3+b];
         end
      end
      if (regs_reg[1][3]) flag_ev[5] = ~flag_sync_reg[5] & flag_prev_reg[5];
      if (regs_reg[3][3]) flag_ev[8] = ~flag_sync_reg[8] & flag_prev_reg[8];
   end

   // Edge select for ep4 lives in no register here; ep4 uses rising edge
   always_comb begin
      for (int i = 0; i < UFIR_NREG; i++) begin
         set_vec[i] = 8'h00;
      end
      wmask[0] = UFIR_FIFO_REQ_MASK;
      wmask[1] = UFIR_FIFO_EN_MASK;
      wmask[2] = UFIR_FIFO_REQ_MASK;
      wmask[3] = UFIR_FIFO_EN_MASK;
      wmask[4] = UFIR_FIFO_REQ_MASK;
      wmask[5] = UFIR_BNAK_MASK;
      wmask[6] = UFIR_BNAK_MASK;
      wmask[7] = UFIR_PNAK_MASK;
      wmask[8] = UFIR_PNAK_MASK;
      wmask[9] = UFIR_BUS_MASK;
      wmask[10] = UFIR_BUS_MASK;
      wmask[11] = UFIR_EP_MASK;
      wmask[12] = UFIR_EP_MASK;
      wmask[13] = UFIR_WAVE_MASK;
      wmask[14] = UFIR_WAVE_MASK;
      wmask[15] = UFIR_ERR_MASK;
      wmask[16] = UFIR_ERR_MASK;
      wmask[17] = 8'h0F;
      wmask[18] = 8'h00;
      wmask[19] = 8'h00;
      wmask[20] = 8'h00;
      set_vec[0] = {5'h00, flag_ev[2:0]};
      set_vec[2] = {5'h00, flag_ev[5:3]};
      set_vec[4] = {5'h00, flag_ev[8:6]};
      set_vec[6] = {2'h0, IN_BULK_NAK_EV};
      set_vec[8] = {PING_NAK_EV, 1'b0, |IN_BULK_NAK_EV};
      set_vec[10] = {1'b0, BUS_EVENT_EV};
      set_vec[12] = ENDPOINT_EV;
      set_vec[14] = {6'h00, WAVEFORM_HOOK_EV, WAVEFORM_DONE_EV};
      set_vec[16] = {ISO_PID_ERR_EV | ISO_DROP_EV, 3'h0, lim_hit};
   end

   // Count saturates at 15; limit reached when count equals limit after increment
   assign lim_hit = (|(ISO_PID_ERR_EV | ISO_DROP_EV))
      && ((err_count_reg + 4'h1) == regs_reg[17][3:0]) && (err_count_reg != 4'hF);

   // AHB address phase
   assign aidx = 5'(HADDR[17:2] - UFIR_IDX_BASE);
   assign aok = (HADDR[17:2] >= UFIR_IDX_BASE) && (HADDR[17:2] <= UFIR_IDX_FIFOVEC);
   assign wdata = HWDATA[7:0];

   always_ff @(posedge CLK or negedge rst_sync_reg) begin
      if (!rst_sync_reg) begin
         state_reg <= UFIR_IDLE;
         widx_reg <= 5'h00;
         wsel_reg <= 1'b0;
      end else begin
         wsel_reg <= 1'b0;
         state_reg <= UFIR_IDLE;
         if (HSEL && HREADY && HTRANS[1]) begin
            widx_reg <= aidx;
            if (HWRITE && aok) begin
               wsel_reg <= 1'b1;
               state_reg <= UFIR_WDATA;
            end
         end
      end
   end

   // Registers: sets win over write-one clears
   always_ff @(posedge CLK or negedge rst_sync_reg) begin
      if (!rst_sync_reg) begin
         for (int i = 0; i < UFIR_NREG; i++) begin
            regs_reg[i] <= UFIR_REG_RESET;
         end
         regs_reg[17] <= {4'h0, UFIR_LIMIT_RESET};
      end else begin
         for (int i = 0; i < UFIR_NREG; i++) begin
            if (i == 17) begin
               if (wsel_reg && widx_reg == 5'(i)) begin
                  regs_reg[i] <= wdata & wmask[i];
               end
            end else if (i[0] == 1'b0 || i == 1 || i == 3) begin
               // Even indices up to 16 (and ep6/ep8 enables) hold enables or requests
               if (i == 0 || i == 2 || i == 4 || i == 6 || i == 8 || i == 10
                   || i == 12 || i == 14 || i == 16) begin
                  if (wsel_reg && widx_reg == 5'(i)) begin
                     regs_reg[i] <= ((regs_reg[i] & ~wdata) | set_vec[i]) & wmask[i];
                  end else begin
                     regs_reg[i] <= (regs_reg[i] | set_vec[i]) & wmask[i];
                  end
               end else if (wsel_reg && widx_reg == 5'(i)) begin
                  regs_reg[i] <= wdata & wmask[i];
               end
            end else if (i < 17 && wsel_reg && widx_reg == 5'(i)) begin
               regs_reg[i] <= wdata & wmask[i];
            end
         end
      end
   end

   // Error counter
   always_ff @(posedge CLK or negedge rst_sync_reg) begin
      if (!rst_sync_reg) begin
         err_count_reg <= 4'h0;
      end else if (wsel_reg && widx_reg == 5'(UFIR_IDX_ERRCLR - UFIR_IDX_BASE)) begin
         err_count_reg <= 4'h0;
      end else if ((|(ISO_PID_ERR_EV | ISO_DROP_EV)) && err_count_reg != 4'hF) begin
         err_count_reg <= err_count_reg + 4'h1;
      end
   end

   // Vectors registered from the prioritiser
   always_ff @(posedge CLK or negedge rst_sync_reg) begin
      if (!rst_sync_reg) begin
         bus_vec_reg <= 5'h00;
         fifo_vec_reg <= 4'h0;
      end else begin
         bus_vec_reg <= BUS_VECTOR_IN;
         fifo_vec_reg <= FIFO_VECTOR_IN;
      end
   end

   // Read data, launched in the address phase so it stands in the data phase
   always_ff @(posedge CLK or negedge rst_sync_reg) begin
      if (!rst_sync_reg) begin
         HRDATA <= 32'h0000_0000;
      end else begin
         HRDATA <= 32'h0000_0000;
         if (HSEL && HREADY && HTRANS[1] && !HWRITE && aok) begin
            if (aidx == 5'd17) begin
               HRDATA <= {24'h000000, err_count_reg, regs_reg[17][3:0]};
            end else if (aidx == 5'd19) begin
               HRDATA <= {24'h000000, 1'b0, bus_vec_reg, 2'b00};
            end else if (aidx == 5'd20) begin
               HRDATA <= {24'h000000, UFIR_FIFOVEC_BASE | {2'b00, fifo_vec_reg, 2'b00}};
            end else if (aidx == 5'd18) begin
               HRDATA <= 32'h0000_0000;
            end else begin
               HRDATA <= {24'h000000, regs_reg[aidx]};
            end
         end
      end
   end

   // Interrupt levels; ep4 has no enable in this group, so its requests pass ungated
   always_ff @(posedge CLK or negedge rst_sync_reg) begin
      if (!rst_sync_reg) begin
         BUS_IRQ <= 1'b0;
         FIFO_IRQ <= 1'b0;
      end else begin
         BUS_IRQ <= |(regs_reg[6] & regs_reg[5]) | |(regs_reg[8] & regs_reg[7])
            | |(regs_reg[10] & regs_reg[9]) | |(regs_reg[12] & regs_reg[11])
            | |(regs_reg[16] & regs_reg[15]);
         FIFO_IRQ <= |(regs_reg[0] & 8'h07) | |(regs_reg[2] & regs_reg[1] & 8'h07)
            | |(regs_reg[4] & regs_reg[3] & 8'h07) | |(regs_reg[14] & regs_reg[13]);
      end
   end

   // Zero wait states and OKAY only; held in flops so every output is registered
   always_ff @(posedge CLK or negedge rst_sync_reg) begin
      if (!rst_sync_reg) begin
         HREADYOUT <= 1'b1;
         HRESP <= 1'b0;
      end else begin
         HREADYOUT <= 1'b1;
         HRESP <= 1'b0;
      end
   end

   chk_clear_one: assert property (@(posedge CLK) disable iff (!rst_sync_reg)
      (wsel_reg && widx_reg == 5'd14 && wdata[0] && !WAVEFORM_DONE_EV)
      |=> !regs_reg[14][0]) else $error("write one did not clear");
   chk_event_sets: assert property (@(posedge CLK) disable iff (!rst_sync_reg)
      WAVEFORM_HOOK_EV |=> regs_reg[14][1]) else $error("hook not latched");
   chk_iso_err: assert property (@(posedge CLK) disable iff (!rst_sync_reg)
      ISO_DROP_EV[0] |=> regs_reg[16][4]) else $error("iso error not latched");
   chk_count_clear: assert property (@(posedge CLK) disable iff (!rst_sync_reg)
      (wsel_reg && widx_reg == 5'd18) |=> err_count_reg == 4'h0) else $error("count not cleared");
   chk_no_sw_set: assert property (@(posedge CLK) disable iff (!rst_sync_reg)
      (!WAVEFORM_DONE_EV && !regs_reg[14][0]) |=> !regs_reg[14][0]) else $error("request set by write");
   chk_ping_nak: assert property (@(posedge CLK) disable iff (!rst_sync_reg)
      PING_NAK_EV[0] |=> regs_reg[8][2]) else $error("ping nak lost");
   chk_bit1_zero: assert property (@(posedge CLK) disable iff (!rst_sync_reg)
      !regs_reg[8][1] && !regs_reg[7][1]) else $error("reserved bit set");
   chk_irq_gate: assert property (@(posedge CLK) disable iff (!rst_sync_reg)
      (regs_reg[12] & regs_reg[11]) != 8'h00 |=> BUS_IRQ) else $error("irq missing");
   chk_limit_hit: assert property (@(posedge CLK) disable iff (!rst_sync_reg)
      lim_hit |=> regs_reg[16][0]) else $error("limit request missing");

   // Bus path, read-only fields, error count and limit, done and PID error requests
   chk_state_wsel: assert property (@(posedge CLK) disable iff (!rst_sync_reg)
      wsel_reg == (state_reg == UFIR_WDATA)) else $error("write strobe out of step");
   chk_bus_okay: assert property (@(posedge CLK) disable iff (!rst_sync_reg)
      HREADYOUT && !HRESP) else $error("wait state or error response");
   chk_rdata_upper: assert property (@(posedge CLK) disable iff (!rst_sync_reg)
      HRDATA[31:8] == 24'h000000) else $error("upper read data not zero");
   chk_done_sets: assert property (@(posedge CLK) disable iff (!rst_sync_reg)
      WAVEFORM_DONE_EV
      |=> regs_reg[14][0]) else $error("done not latched");
   chk_wave_unused: assert property (@(posedge CLK) disable iff (!rst_sync_reg)
      regs_reg[14][7:2] == 6'h00 && regs_reg[13][7:2] == 6'h00) else $error("wave bit set");
   chk_iso_pid: assert property (@(posedge CLK) disable iff (!rst_sync_reg)
      ISO_PID_ERR_EV[3]
      |=> regs_reg[16][7]) else $error("pid error not latched");
   chk_limit_write: assert property (@(posedge CLK) disable iff (!rst_sync_reg)
      (wsel_reg && widx_reg == 5'd17)
      |=> regs_reg[17] == ($past(wdata) & 8'h0F)) else $error("limit not stored");
   chk_count_step: assert property (@(posedge CLK) disable iff (!rst_sync_reg)
      ((|(ISO_PID_ERR_EV | ISO_DROP_EV)) && err_count_reg != 4'hF && !(wsel_reg && widx_reg == 5'd18))
      |=> err_count_reg == $past(err_count_reg) + 4'h1) else $error("count did not step");
   chk_count_sat: assert property (@(posedge CLK) disable iff (!rst_sync_reg)
      (err_count_reg == 4'hF && !(wsel_reg && widx_reg == 5'd18))
      |=> err_count_reg == 4'hF) else $error("count wrapped");
   chk_bus_vec_rd: assert property (@(posedge CLK) disable iff (!rst_sync_reg)
      (HSEL && HREADY && HTRANS[1] && !HWRITE && aok && aidx == 5'd19)
      |=> HRDATA[7:0] == {1'b0, $past(bus_vec_reg), 2'b00}) else $error("bus vector wrong");
   chk_fifo_vec_rd: assert property (@(posedge CLK) disable iff (!rst_sync_reg)
      (HSEL && HREADY && HTRANS[1] && !HWRITE && aok && aidx == 5'd20)
      |=> HRDATA[7:0] == {2'b10, $past(fifo_vec_reg), 2'b00}) else $error("fifo vector wrong");
   chk_clr_reads_zero: assert property (@(posedge CLK) disable iff (!rst_sync_reg)
      (HSEL && HREADY && HTRANS[1] && !HWRITE && aok && aidx == 5'd18)
      |=> HRDATA == 32'h0000_0000) else $error("clear register read nonzero");

   // Request setting and clearing, enables and interrupt gating
   chk_pnak_sum: assert property (@(posedge CLK) disable iff (!rst_sync_reg)
      (|IN_BULK_NAK_EV)
      |=> regs_reg[8][0]) else $error("summary bit not set");
   chk_pnak_ep8: assert property (@(posedge CLK) disable iff (!rst_sync_reg)
      PING_NAK_EV[5]
      |=> regs_reg[8][7]) else $error("ep8 ping nak lost");
   chk_fifo_en_top: assert property (@(posedge CLK) disable iff (!rst_sync_reg)
      regs_reg[1][7:4] == 4'h0 && regs_reg[3][7:4] == 4'h0) else $error("fifo enable high bit");
   chk_ep6_fall: assert property (@(posedge CLK) disable iff (!rst_sync_reg)
      (regs_reg[1][3] && !flag_sync_reg[5] && flag_prev_reg[5])
      |=> regs_reg[2][2]) else $error("falling level flag lost");
   chk_ep6_rise: assert property (@(posedge CLK) disable iff (!rst_sync_reg)
      (!regs_reg[1][3] && flag_sync_reg[5] && !flag_prev_reg[5])
      |=> regs_reg[2][2]) else $error("rising level flag lost");
   chk_err_gap: assert property (@(posedge CLK) disable iff (!rst_sync_reg)
      regs_reg[15][3:1] == 3'h0 && regs_reg[16][3:1] == 3'h0) else $error("error gap bit set");
   chk_bus_irq_off: assert property (@(posedge CLK) disable iff (!rst_sync_reg)
      ((regs_reg[6] & regs_reg[5]) | (regs_reg[8] & regs_reg[7]) | (regs_reg[10] & regs_reg[9])
      | (regs_reg[12] & regs_reg[11]) | (regs_reg[16] & regs_reg[15])) == 8'h00
      |=> !BUS_IRQ) else $error("irq without source");
   chk_fifo_irq_on: assert property (@(posedge CLK) disable iff (!rst_sync_reg)
      (regs_reg[14] & regs_reg[13]) != 8'h00
      |=> FIFO_IRQ) else $error("fifo irq missing");
   chk_lim_clear: assert property (@(posedge CLK) disable iff (!rst_sync_reg)
      (wsel_reg && widx_reg == 5'd16 && wdata[0] && !lim_hit)
      |=> !regs_reg[16][0]) else $error("limit request not cleared");

   cov_wave_done: cover property (@(posedge CLK) WAVEFORM_DONE_EV ##2 FIFO_IRQ);
   cov_flag_fall: cover property (@(posedge CLK) regs_reg[1][3] && !flag_sync_reg[5] && flag_prev_reg[5]);
   cov_bus_irq: cover property (@(posedge CLK) BUS_IRQ ##1 !BUS_IRQ);
   cov_limit: cover property (@(posedge CLK) lim_hit);
   cov_clear: cover property (@(posedge CLK) wsel_reg && widx_reg == 5'd18);
endmodule
`default_nettype wire

// *** usb_fifo_interrupt_requests_tb.sv ***
// Purpose: self-checking bench for the USB FIFO interrupt request registers
// Assumes: zero-wait AHB-Lite slave; byte address is four times the register index
// Notes: reads queue their expected value; a monitor compares when data returns
`timescale 1ns/1ps
`default_nettype none
module usb_fifo_interrupt_requests_tb;
   import ufir_pkg::*;
   logic CLK, NRST, HSEL, HWRITE, HREADY, HREADYOUT, HRESP, BUS_IRQ, FIFO_IRQ;
   logic [17:0] HADDR;
   logic [1:0] HTRANS, wv;
   logic [2:0] HSIZE, ep4_f, ep6_f, ep8_f;
   logic [31:0] HWDATA, HRDATA, rd_val, r;
   logic [4:0] bvec;
   logic [3:0] fvec, pe, dr;
   logic [6:0] bev;
   logic [7:0] eev;
   logic [5:0] pn, ib;
   logic [15:0] rm;
   logic [63:0] m;
   logic [63:0] exp_q[$];
   int num_errors = 0;
   int total_checks = 0;
   int seed = 27618;
   event rd_ev;
   logic [15:0] en_idx [8] = '{UFIR_IDX_EP6_EN, UFIR_IDX_EP8_EN, UFIR_IDX_BNAK_EN,
      UFIR_IDX_PNAK_EN, UFIR_IDX_BUS_EN, UFIR_IDX_EP_EN, UFIR_IDX_WAVE_EN, UFIR_IDX_ERR_EN};
   logic [7:0] en_val [8] = '{8'h0F, 8'h0F, 8'h3F, 8'hFD, 8'h7F, 8'hFF, 8'h03, 8'hF1};
   assign HREADY = HREADYOUT;
   initial begin
      CLK = 1'b0;
      forever #2.5 CLK = ~CLK;
   end
   ufir_top dut (.CLK(CLK), .NRST(NRST), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
      .HWRITE(HWRITE), .HSIZE(HSIZE), .HREADY(HREADY), .HWDATA(HWDATA), .HRDATA(HRDATA),
      .HREADYOUT(HREADYOUT), .HRESP(HRESP), .EP4_FLAG_IN(ep4_f), .EP6_FLAG_IN(ep6_f),
      .EP8_FLAG_IN(ep8_f), .IN_BULK_NAK_EV(ib), .PING_NAK_EV(pn), .BUS_EVENT_EV(bev),
      .ENDPOINT_EV(eev), .WAVEFORM_HOOK_EV(wv[1]), .WAVEFORM_DONE_EV(wv[0]),
      .ISO_PID_ERR_EV(pe), .ISO_DROP_EV(dr), .BUS_VECTOR_IN(bvec), .FIFO_VECTOR_IN(fvec),
      .BUS_IRQ(BUS_IRQ), .FIFO_IRQ(FIFO_IRQ));
   ufir_evt_model mdl (.clk(CLK), .bus_ev(bev), .ep_ev(eev), .pnak_ev(pn), .ibn_ev(ib),
      .pid_ev(pe), .drop_ev(dr), .wave_ev(wv));
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic summarize();
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // Hold each phase until ready is seen; only the watchdog ends a stuck wait
   task automatic xfer(input logic [15:0] idx, input logic w, input logic [7:0] d,
      output logic [31:0] rdat);
      begin
         HSEL <= 1'b1;
         HADDR <= {idx, 2'b00};
         HTRANS <= 2'b10;
         HWRITE <= w;
         do @(posedge CLK); while (HREADY !== 1'b1);
         HSEL <= 1'b0;
         HTRANS <= 2'b00;
         HWDATA <= {24'h0, d};
         do @(posedge CLK); while (HREADY !== 1'b1);
         rdat = HRDATA;
      end
   endtask
   task automatic wr(input logic [15:0] idx, input logic [7:0] d);
      logic [31:0] t;
      xfer(idx, 1'b1, d, t);
   endtask
   // Upper 24 bits must always read zero, so they stay in the mask
   task automatic rd(input logic [15:0] idx, input logic [7:0] e, input logic [7:0] k = 8'hFF);
      logic [31:0] t;
      xfer(idx, 1'b0, 8'h00, t);
      exp_q.push_back({24'hFFFFFF, k, 24'h0, e & k});
      rd_val = t;
      -> rd_ev;
   endtask
   task automatic irq_after(input logic [1:0] e);
      repeat (2) @(posedge CLK);
      check("irq", {30'h0, BUS_IRQ, FIFO_IRQ}, {30'h0, e});
   endtask
   function automatic logic [15:0] rst_exp(input logic [15:0] idx);
      case (idx)
         UFIR_IDX_BNAK_REQ: return 16'hC000;
         UFIR_IDX_PNAK_REQ: return 16'h0200;
         UFIR_IDX_BUS_REQ: return 16'h8000;
         UFIR_IDX_WAVE_REQ: return 16'hFC00;
         UFIR_IDX_ERR_REQ: return 16'hFE00;
         UFIR_IDX_ERRCNT: return 16'h0F04;
         UFIR_IDX_ERRCLR: return 16'h0000;
         UFIR_IDX_FIFOVEC: return 16'hFF80;
         default: return 16'hFF00;
      endcase
   endfunction
   initial begin
      forever begin
         @(rd_ev);
         m = exp_q.pop_front();
         check("hrdata", rd_val & m[63:32], m[31:0]);
         check("hresp", {31'h0, HRESP}, 32'h0);
         check("hready", {31'h0, HREADYOUT}, 32'h1);
      end
   end
   initial begin
      repeat (20000) @(posedge CLK);
      num_errors++;
      summarize();
   end
   initial begin
      NRST = 1'b0;
      {HSEL, HWRITE, HTRANS, HADDR, HWDATA, ep4_f, ep6_f, ep8_f, bvec, fvec} = '0;
      HSIZE = 3'b010;
      repeat (8) @(posedge CLK);
      NRST <= 1'b1;
      repeat (4) @(posedge CLK);
      for (int i = 0; i < 21; i++) begin
         rm = rst_exp(UFIR_IDX_BASE + 16'(i));
         rd(UFIR_IDX_BASE + 16'(i), rm[7:0], rm[15:8]);
      end
      for (int i = 0; i < 8; i++) begin
         wr(en_idx[i], 8'hFF);
         rd(en_idx[i], en_val[i]);
      end
      for (int i = 0; i < 9; i++) begin
         wr(UFIR_IDX_BASE + 16'(2 * i), 8'hFF);
         rd(UFIR_IDX_BASE + 16'(2 * i), 8'h00);
      end
      irq_after(2'b00);
      for (int i = 0; i < 3; i++) begin
         r = $random(seed);
         bvec <= r[28:24];
         fvec <= r[31:28];
         mdl.pulse(r[6:0], r[14:7], 6'h0, 6'h0, 4'h0, 4'h0, 2'h0);
         rd(UFIR_IDX_BUS_REQ, {1'b0, r[6:0]});
         rd(UFIR_IDX_EP_REQ, r[14:7]);
         wr(UFIR_IDX_BUS_REQ, r[23:16]);
         rd(UFIR_IDX_BUS_REQ, {1'b0, r[6:0]} & ~r[23:16]);
         wr(UFIR_IDX_BUS_REQ, 8'hFF);
         wr(UFIR_IDX_EP_REQ, 8'hFF);
         wr(UFIR_IDX_BUSVEC, 8'hFF);
         rd(UFIR_IDX_BUSVEC, {1'b0, r[28:24], 2'b00});
         rd(UFIR_IDX_FIFOVEC, {2'b10, r[31:28], 2'b00});
      end
      mdl.pulse(7'h08, 8'h0, 6'h0, 6'h0, 4'h0, 4'h0, 2'h0);
      irq_after(2'b10);
      wr(UFIR_IDX_BUS_EN, 8'h00);
      irq_after(2'b00);
      wr(UFIR_IDX_BUS_EN, 8'h7F);
      irq_after(2'b10);
      wr(UFIR_IDX_BUS_REQ, 8'h08);
      irq_after(2'b00);
      mdl.pulse(7'h0, 8'h0, 6'h0, 6'h0, 4'h0, 4'h0, 2'h3);
      rd(UFIR_IDX_WAVE_REQ, 8'h03);
      irq_after(2'b01);
      wr(UFIR_IDX_WAVE_REQ, 8'h01);
      rd(UFIR_IDX_WAVE_REQ, 8'h02);
      wr(UFIR_IDX_WAVE_REQ, 8'h02);
      mdl.pulse(7'h0, 8'h0, 6'h3F, 6'h01, 4'h0, 4'h0, 2'h0);
      rd(UFIR_IDX_PNAK_REQ, 8'hFD);
      rd(UFIR_IDX_BNAK_REQ, 8'h01);
      wr(UFIR_IDX_PNAK_REQ, 8'hFF);
      wr(UFIR_IDX_BNAK_REQ, 8'hFF);
      wr(UFIR_IDX_ERRCNT, 8'h03);
      mdl.pulse(7'h0, 8'h0, 6'h0, 6'h0, 4'h0, 4'h1, 2'h0);
      mdl.pulse(7'h0, 8'h0, 6'h0, 6'h0, 4'h8, 4'h0, 2'h0);
      rd(UFIR_IDX_ERR_REQ, 8'h90);
      rd(UFIR_IDX_ERRCNT, 8'h23);
      mdl.pulse(7'h0, 8'h0, 6'h0, 6'h0, 4'h2, 4'h0, 2'h0);
      rd(UFIR_IDX_ERR_REQ, 8'hB1);
      wr(UFIR_IDX_ERRCLR, 8'h5A);
      rd(UFIR_IDX_ERRCNT, 8'h03);
      wr(UFIR_IDX_ERRCNT, 8'hF7);
      rd(UFIR_IDX_ERRCNT, 8'h07);
      wr(UFIR_IDX_ERR_REQ, 8'hFF);
      // Edge select is set on endpoints 6 and 8, so their level flag waits for the fall
      {ep4_f, ep6_f, ep8_f} <= 9'h1FF;
      repeat (6) @(posedge CLK);
      rd(UFIR_IDX_EP4_REQ, 8'h07);
      rd(UFIR_IDX_EP6_REQ, 8'h03);
      rd(UFIR_IDX_EP8_REQ, 8'h03);
      irq_after(2'b01);
      {ep4_f, ep6_f, ep8_f} <= 9'h000;
      repeat (6) @(posedge CLK);
      rd(UFIR_IDX_EP6_REQ, 8'h07);
      rd(UFIR_IDX_EP8_REQ, 8'h07);
      // Edge select off again: the level flag of endpoint 6 now counts on the rise
      wr(UFIR_IDX_EP6_REQ, 8'hFF);
      wr(UFIR_IDX_EP6_EN, 8'h07);
      {ep4_f, ep6_f, ep8_f} <= 9'h1FF;
      repeat (6) @(posedge CLK);
      rd(UFIR_IDX_EP6_REQ, 8'h07);
      wr(16'hE668, 8'hFF);
      rd(16'hE668, 8'h00);
      rd(16'h0000, 8'h00);
      repeat (2) @(posedge CLK);
      summarize();
   end
endmodule
`default_nettype wire
